// ### design/chsc_defines.svh
// Constants for the card host-space configuration block
`ifndef CHSC_DEFINES_SVH
`define CHSC_DEFINES_SVH
`define CHSC_AW            11
`define CHSC_DW            8
`define CHSC_CFG_OPTION    11'h200
`define CHSC_CFG_STATUS    11'h202
`define CHSC_PIN_REPL      11'h204
`define CHSC_SOCKET_COPY   11'h206
`define CHSC_CFG_RESET     8'h00
`define CHSC_IDX_MSB       5
`define CHSC_IDX_MEM       6'h00
`define CHSC_IDX_CONT      6'h01
`define CHSC_IDX_PRI       6'h02
`define CHSC_IDX_SEC       6'h03
`define CHSC_TF_BLOCK      8'h00
`define CHSC_PRI_BLOCK     8'h3e
`define CHSC_SEC_BLOCK     8'h2e
`define CHSC_CIS_BLOCK     7'h00
`define CHSC_CIS_END       8'hff
`define CHSC_SETTLE_CYC    2'h3
`define CHSC_STROBE_CYC    4'h6
`define CHSC_GAP_CYC       4'h4
`define CHSC_REG_ADDR_LO   4'h0
`define CHSC_REG_ADDR_HI   4'h1
`define CHSC_REG_WDATA     4'h2
`define CHSC_REG_CMD       4'h3
`define CHSC_REG_STATUS    4'h4
`define CHSC_REG_RDATA     4'h5
`define CHSC_CMD_READ_BIT  0
`define CHSC_SPC_ATTR      2'h0
`define CHSC_SPC_COMMON    2'h1
`define CHSC_SPC_IO        2'h2
`endif

// ### design/chsc_pkg.sv
// Types shared by both ends of the card host-space link
package chsc_pkg;
   typedef enum logic [4:0] {
      CHSC_MODE_MEM  = 5'b00001,
      CHSC_MODE_CONT = 5'b00010,
      CHSC_MODE_PRI  = 5'b00100,
      CHSC_MODE_SEC  = 5'b01000,
      CHSC_MODE_IDE  = 5'b10000
   } chsc_mode_e;
   typedef enum logic [3:0] {
      CHSC_ST_IDLE   = 4'b0001,
      CHSC_ST_SETUP  = 4'b0010,
      CHSC_ST_STROBE = 4'b0100,
      CHSC_ST_GAP    = 4'b1000
   } chsc_state_e;
endpackage : chsc_pkg

// ### design/chsc_if.sv
// Card socket pins joining the host end and the card end
`timescale 1ns/1ns
`include "chsc_defines.svh"
interface chsc_if;
   logic [`CHSC_AW-1:0] addr;
   logic [`CHSC_DW-1:0] host_d;
   logic                host_d_oe_n;
   logic [`CHSC_DW-1:0] card_d;
   logic                card_d_oe_n;
   logic                card_en_n;
   logic                mem_rd_n;
   logic                mem_wr_n;
   logic                io_rd_n;
   logic                io_wr_n;
   logic                attr_sel_n;
   logic [`CHSC_DW-1:0] data;
   // Resolved data wire; an undriven bus floats high
   assign data = !host_d_oe_n ? host_d : (!card_d_oe_n ? card_d : {`CHSC_DW{1'b1}});
   modport host (output addr, host_d, host_d_oe_n, card_en_n, mem_rd_n, mem_wr_n,
                 io_rd_n, io_wr_n, attr_sel_n, input data);
   modport card (input addr, card_en_n, mem_rd_n, mem_wr_n, io_rd_n, io_wr_n,
                 attr_sel_n, data, output card_d, card_d_oe_n);
endinterface : chsc_if

// ### design/chsc_card.sv
// Card end: interface select, space decode, configuration registers, CIS
// Function
// - Interface chosen by output-enable level at power-on
// - Memory by read/write enables, I/O by I/O strobes
// - Register select low attribute, high common
// - Host chooses memory or I/O command file
// - IDE mode decodes only I/O space
// - No direct host path into data area
// - Configuration registers single bytes, even addresses
// - Four registers from base, steps of two
// - Index is low six option bits
// - Index 0 memory, 1 contiguous, 2 primary, 3 secondary
// - Mode changes only after index write
// - Host reads CIS before writing index
// - Command file common memory or I/O space
// - IDE mode decodes command file at every I/O address
// - CIS tuples even addresses, chained from zero
`timescale 1ns/1ns
`include "chsc_defines.svh"
module chsc_card
   import chsc_pkg::*;
(
   input  wire logic                CLK_SYS_I,
   input  wire logic                NRST_I,
   chsc_if.card                     CARD,
   output logic                     TRUE_IDE_O,
   output logic                     READY_O,
   output logic [4:0]               MODE_O,
   output logic                     TF_WR_O,
   output logic [2:0]               TF_ADDR_O,
   output logic [`CHSC_DW-1:0]      TF_DATA_O
);
   logic [1:0]          s_en_n;
   logic [1:0]          s_mrd_n;
   logic [1:0]          s_mwr_n;
   logic [1:0]          s_ird_n;
   logic [1:0]          s_iwr_n;
   logic [1:0]          s_reg_n;
   logic                mwr_q;
   logic                iwr_q;
   logic [1:0]          settle;
   logic                ide;
   logic                ready;
   logic [`CHSC_DW-1:0] cfg_option;
   logic [`CHSC_DW-1:0] cfg_status;
   logic [`CHSC_DW-1:0] pin_repl;
   logic [`CHSC_DW-1:0] socket_copy;
   logic [`CHSC_DW-1:0] tf [0:7];
   chsc_mode_e          mode;
   logic                mem_rd;
   logic                mem_wr;
   logic                io_rd;
   logic                io_wr;
   logic                attr_rd;
   logic                attr_wr;
   logic                tf_rd;
   logic                tf_wr;
   logic                mwr_edge;
   logic                iwr_edge;
   logic [3:0]          tf_hit;
   logic [`CHSC_DW-1:0] next_rdata;

   // Index decode; reserved index values fall back to the memory map
   function automatic chsc_mode_e idx_mode(input logic [`CHSC_IDX_MSB:0] idx);
      if (idx == `CHSC_IDX_CONT)
         idx_mode = CHSC_MODE_CONT;
      else if (idx == `CHSC_IDX_PRI)
         idx_mode = CHSC_MODE_PRI;
      else if (idx == `CHSC_IDX_SEC)
         idx_mode = CHSC_MODE_SEC;
      else
         idx_mode = CHSC_MODE_MEM;
   endfunction : idx_mode

   // Command file decode: {hit, register index}
   function automatic logic [3:0] tf_decode(input chsc_mode_e m,
                                            input logic [`CHSC_AW-1:0] a);
      logic [7:0] blk;
      blk = a[`CHSC_AW-1:3];
      tf_decode = {1'b0, a[2:0]};
      case (m)
         CHSC_MODE_MEM, CHSC_MODE_CONT: tf_decode[3] = (blk == `CHSC_TF_BLOCK);
         CHSC_MODE_PRI:                 tf_decode[3] = (blk == `CHSC_PRI_BLOCK);
         CHSC_MODE_SEC:                 tf_decode[3] = (blk == `CHSC_SEC_BLOCK);
         CHSC_MODE_IDE:                 tf_decode[3] = 1'b1;
         default:                       tf_decode[3] = 1'b0;
      endcase
   endfunction : tf_decode

   // Card information tuples: device tuple then end of list
   function automatic logic [`CHSC_DW-1:0] cis_byte(input logic [`CHSC_AW-1:0] a);
      cis_byte = 8'h00;
      if (a[0] || a[`CHSC_AW-1:4] != `CHSC_CIS_BLOCK)
         cis_byte = 8'h00;
      else if (a[3:1] == 3'h0)
         cis_byte = 8'h01;
      else if (a[3:1] == 3'h1)
         cis_byte = 8'h02;
      else if (a[3:1] == 3'h2)
         cis_byte = 8'hd9;
      else if (a[3:1] == 3'h3)
         cis_byte = 8'h01;
      else
         cis_byte = `CHSC_CIS_END;
   endfunction : cis_byte

   // Socket control pins come from the other end; two flops before any use, address and data used directly
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         s_en_n  <= 2'h3;
         s_mrd_n <= 2'h3;
         s_mwr_n <= 2'h3;
         s_ird_n <= 2'h3;
         s_iwr_n <= 2'h3;
         s_reg_n <= 2'h3;
      end else begin
         s_en_n  <= {s_en_n[0], CARD.card_en_n};
         s_mrd_n <= {s_mrd_n[0], CARD.mem_rd_n};
         s_mwr_n <= {s_mwr_n[0], CARD.mem_wr_n};
         s_ird_n <= {s_ird_n[0], CARD.io_rd_n};
         s_iwr_n <= {s_iwr_n[0], CARD.io_wr_n};
         s_reg_n <= {s_reg_n[0], CARD.attr_sel_n};
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         mwr_q <= 1'b0;
         iwr_q <= 1'b0;
      end else begin
         mwr_q <= mem_wr;
         iwr_q <= io_wr;
      end
   end

   // Interface choice is caught once the synchronisers have settled
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         settle <= 2'h0;
         ide    <= 1'b0;
         ready  <= 1'b0;
      end else if (!ready) begin
         if (settle == `CHSC_SETTLE_CYC) begin
            ide   <= !s_mrd_n[1];
            ready <= 1'b1;
         end else begin
            settle <= settle + 2'h1;
         end
      end
   end

   // Memory strobes exist only outside IDE mode
   assign mem_rd = ready && !ide && !s_en_n[1] && !s_mrd_n[1];
   assign mem_wr = ready && !ide && !s_en_n[1] && !s_mwr_n[1];
   assign io_rd  = ready && !s_en_n[1] && !s_ird_n[1];
   assign io_wr  = ready && !s_en_n[1] && !s_iwr_n[1];
   assign mwr_edge = mem_wr && !mwr_q;
   assign iwr_edge = io_wr && !iwr_q;

   always_comb begin
      mode = ide ? CHSC_MODE_IDE : idx_mode(cfg_option[`CHSC_IDX_MSB:0]);
   end

   assign tf_hit  = tf_decode(mode, CARD.addr);
   assign attr_rd = mem_rd && !s_reg_n[1];
   assign attr_wr = mwr_edge && !s_reg_n[1];
   // Command file follows the space the host selected by index
   assign tf_rd = tf_hit[3] && ((mode == CHSC_MODE_MEM) ? (mem_rd && s_reg_n[1])
                                 : io_rd);
   assign tf_wr = tf_hit[3] && ((mode == CHSC_MODE_MEM) ? (mwr_edge && s_reg_n[1])
                                 : iwr_edge);

   // Configuration registers; written once per write strobe
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         cfg_option  <= `CHSC_CFG_RESET;
         cfg_status  <= `CHSC_CFG_RESET;
         pin_repl    <= `CHSC_CFG_RESET;
         socket_copy <= `CHSC_CFG_RESET;
      end else if (attr_wr) begin
         if (CARD.addr == `CHSC_CFG_OPTION)
            cfg_option <= CARD.data;
         else if (CARD.addr == `CHSC_CFG_STATUS)
            cfg_status <= CARD.data;
         else if (CARD.addr == `CHSC_PIN_REPL)
            pin_repl <= CARD.data;
         else if (CARD.addr == `CHSC_SOCKET_COPY)
            socket_copy <= CARD.data;
      end
   end

   // Command file holds bytes only; stored data is read back to the host through tf_rd
   always_ff @(posedge CLK_SYS_I) begin
      if (tf_wr)
         tf[tf_hit[2:0]] <= CARD.data;
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         TF_WR_O   <= 1'b0;
         TF_ADDR_O <= 3'h0;
         TF_DATA_O <= 8'h00;
      end else begin
         TF_WR_O <= tf_wr;
         if (tf_wr) begin
            TF_ADDR_O <= tf_hit[2:0];
            TF_DATA_O <= CARD.data;
         end
      end
   end

   // Read mux; attribute space is invisible in IDE mode since mem_rd is low
   always_comb begin
      next_rdata = 8'h00;
      if (tf_rd)
         next_rdata = tf[tf_hit[2:0]];
      else if (attr_rd) begin
         if (CARD.addr == `CHSC_CFG_OPTION)
            next_rdata = cfg_option;
         else if (CARD.addr == `CHSC_CFG_STATUS)
            next_rdata = cfg_status;
         else if (CARD.addr == `CHSC_PIN_REPL)
            next_rdata = pin_repl;
         else if (CARD.addr == `CHSC_SOCKET_COPY)
            next_rdata = socket_copy;
         else
            next_rdata = cis_byte(CARD.addr);
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         CARD.card_d      <= 8'h00;
         CARD.card_d_oe_n <= 1'b1;
      end else begin
         CARD.card_d      <= next_rdata;
         CARD.card_d_oe_n <= !(tf_rd || attr_rd);
      end
   end

   assign TRUE_IDE_O = ide;
   assign READY_O    = ready;
   assign MODE_O     = mode;
endmodule : chsc_card

// ### design/chsc_host.sv
// Host end: strap drive and sequenced socket accesses under register control
`timescale 1ns/1ns
`include "chsc_defines.svh"
module chsc_host
   import chsc_pkg::*;
(
   input  wire logic                CLK_SYS_I,
   input  wire logic                NRST_I,
   input  wire logic                IDE_SEL_I,
   input  wire logic [3:0]          ADDR_I,
   input  wire logic [`CHSC_DW-1:0] WDATA_I,
   input  wire logic                WR_I,
   input  wire logic                RD_I,
   output logic [`CHSC_DW-1:0]      RDATA_O,
   chsc_if.host                     SOCK
);
   chsc_state_e         state;
   logic [3:0]          cnt;
   logic                ide;
   logic [`CHSC_AW-1:0] acc_addr;
   logic [`CHSC_DW-1:0] acc_wdata;
   logic [`CHSC_DW-1:0] acc_rdata;
   logic                acc_read;
   logic [1:0]          acc_space;
   logic                busy;
   logic                strobe;
   logic [1:0]          s_ide_sel;

   assign busy   = (state != CHSC_ST_IDLE);
   assign strobe = (state == CHSC_ST_STROBE);

   // Strap pin is not tied to the host clock; two flops before any use
   always_ff @(posedge CLK_SYS_I) begin
      s_ide_sel <= {s_ide_sel[0], IDE_SEL_I};
   end

   // Interface strap is held into the card through reset and frozen after
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I)
         ide <= s_ide_sel[1];
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         acc_addr  <= 11'h000;
         acc_wdata <= 8'h00;
         acc_read  <= 1'b0;
         acc_space <= `CHSC_SPC_ATTR;
      end else if (WR_I && !busy) begin
         if (ADDR_I == `CHSC_REG_ADDR_LO)
            acc_addr[7:0] <= WDATA_I;
         else if (ADDR_I == `CHSC_REG_ADDR_HI)
            acc_addr[`CHSC_AW-1:8] <= WDATA_I[2:0];
         else if (ADDR_I == `CHSC_REG_WDATA)
            acc_wdata <= WDATA_I;
         else if (ADDR_I == `CHSC_REG_CMD) begin
            acc_read  <= WDATA_I[`CHSC_CMD_READ_BIT];
            // IDE has I/O space only
            acc_space <= ide ? `CHSC_SPC_IO : WDATA_I[2:1];
         end
      end
   end

   // Access sequencer; strobe length covers the card's input synchronisers
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         state <= CHSC_ST_IDLE;
         cnt   <= 4'h0;
      end else begin
         case (state)
            CHSC_ST_IDLE: begin
               if (WR_I && ADDR_I == `CHSC_REG_CMD)
                  state <= CHSC_ST_SETUP;
            end
            CHSC_ST_SETUP: begin
               state <= CHSC_ST_STROBE;
               cnt   <= 4'h0;
            end
            CHSC_ST_STROBE: begin
               cnt <= cnt + 4'h1;
               if (cnt == `CHSC_STROBE_CYC - 4'h1) begin
                  state <= CHSC_ST_GAP;
                  cnt   <= 4'h0;
               end
            end
            CHSC_ST_GAP: begin
               cnt <= cnt + 4'h1;
               if (cnt == `CHSC_GAP_CYC - 4'h1)
                  state <= CHSC_ST_IDLE;
            end
            default: state <= CHSC_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I)
         acc_rdata <= 8'h00;
      else if (strobe && acc_read && cnt == `CHSC_STROBE_CYC - 4'h1)
         acc_rdata <= SOCK.data;
   end

   // Pins; in IDE mode the output enable line stays grounded
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         SOCK.addr        <= 11'h000;
         SOCK.host_d      <= 8'h00;
         SOCK.host_d_oe_n <= 1'b1;
         SOCK.card_en_n   <= 1'b1;
         SOCK.mem_rd_n    <= !s_ide_sel[1];
         SOCK.mem_wr_n    <= 1'b1;
         SOCK.io_rd_n     <= 1'b1;
         SOCK.io_wr_n     <= 1'b1;
         SOCK.attr_sel_n  <= 1'b1;
      end else begin
         SOCK.addr        <= acc_addr;
         SOCK.host_d      <= acc_wdata;
         SOCK.host_d_oe_n <= !(busy && !acc_read && state != CHSC_ST_GAP);
         SOCK.card_en_n   <= !(state == CHSC_ST_SETUP || strobe);
         SOCK.attr_sel_n  <= (acc_space != `CHSC_SPC_ATTR);
         SOCK.mem_rd_n    <= ide ? 1'b0 : !(strobe && acc_read && acc_space != `CHSC_SPC_IO);
         SOCK.mem_wr_n    <= !(strobe && !acc_read && acc_space != `CHSC_SPC_IO);
         SOCK.io_rd_n     <= !(strobe && acc_read && acc_space == `CHSC_SPC_IO);
         SOCK.io_wr_n     <= !(strobe && !acc_read && acc_space == `CHSC_SPC_IO);
      end
   end

   // Register read port: data in the cycle after the strobe
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I)
         RDATA_O <= 8'h00;
      else if (RD_I) begin
         if (ADDR_I == `CHSC_REG_ADDR_LO)
            RDATA_O <= acc_addr[7:0];
         else if (ADDR_I == `CHSC_REG_ADDR_HI)
            RDATA_O <= {5'h00, acc_addr[`CHSC_AW-1:8]};
         else if (ADDR_I == `CHSC_REG_WDATA)
            RDATA_O <= acc_wdata;
         else if (ADDR_I == `CHSC_REG_CMD)
            RDATA_O <= {5'h00, acc_space, acc_read};
         else if (ADDR_I == `CHSC_REG_STATUS)
            RDATA_O <= {6'h00, ide, busy};
         else if (ADDR_I == `CHSC_REG_RDATA)
            RDATA_O <= acc_rdata;
         else
            RDATA_O <= 8'h00;
      end else
         RDATA_O <= 8'h00;
   end
endmodule : chsc_host

// ### dv/chsc_props.sv
// Concurrent checks on the socket signals between host and card ends
`timescale 1ns/1ns
`include "chsc_defines.svh"
module chsc_props (
   input  wire logic                CLK_SYS_I,
   input  wire logic                NRST_I,
   input  wire logic [`CHSC_AW-1:0] addr,
   input  wire logic [`CHSC_DW-1:0] host_d,
   input  wire logic                host_d_oe_n,
   input  wire logic                card_d_oe_n,
   input  wire logic                card_en_n,
   input  wire logic                mem_rd_n,
   input  wire logic                mem_wr_n,
   input  wire logic                io_rd_n,
   input  wire logic                io_wr_n,
   input  wire logic                attr_sel_n
);
   default clocking cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!NRST_I);
   // Strobe low for exactly six cycles, then released
   sequence s_low6(sig);
      (!sig)[*6] ##1 sig;
   endsequence
   // Read strobe of either space; mem_rd_n also carries the IDE strap
   sequence s_any_rd;
      !io_rd_n || !mem_rd_n;
   endsequence
   AST_IO_RD_LEN: assert property ($fell(io_rd_n) |-> s_low6(io_rd_n))
      else $error("io read strobe length wrong");
   AST_MEM_WR_LEN: assert property ($fell(mem_wr_n) |-> s_low6(mem_wr_n))
      else $error("memory write strobe length wrong");
   AST_STROBE_SELECT: assert property ((!io_rd_n || !io_wr_n || !mem_wr_n) |-> !card_en_n)
      else $error("strobe without card enable");
   AST_WR_HOST_DRIVES: assert property ((!io_wr_n || !mem_wr_n) |-> !host_d_oe_n && card_d_oe_n)
      else $error("write strobe without host data drive");
   AST_WR_HOLD: assert property (!io_wr_n && $past(!io_wr_n) |-> $stable(addr) && $stable(host_d))
      else $error("address or data moved inside write strobe");
   AST_NO_FIGHT: assert property (host_d_oe_n || card_d_oe_n)
      else $error("host and card drive data together");
   AST_ATTR_RD_ANSWER: assert property ($fell(mem_rd_n) && !attr_sel_n |-> ##[2:4] !card_d_oe_n)
      else $error("attribute read not answered");
   AST_RD_RELEASE: assert property ($rose(io_rd_n) || $rose(mem_rd_n) |-> ##[1:4] card_d_oe_n)
      else $error("card kept data bus after read");
   AST_IDLE_RELEASE: assert property (card_en_n[*4] |-> card_d_oe_n)
      else $error("card drives while not enabled");
   AST_DRIVE_AFTER_READ: assert property ($fell(card_d_oe_n) |-> $past(!io_rd_n || !mem_rd_n))
      else $error("card drives without read strobe");
   COV_ANY_RD: cover property (s_any_rd ##1 !card_d_oe_n);
endmodule : chsc_props

// ### dv/tb_card_host_space_config.sv
// Self-checking bench joining host and card ends over the socket
`timescale 1ns/1ns
`include "chsc_defines.svh"
module tb_card_host_space_config
   import chsc_pkg::*;
;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        ide_sel = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [7:0]  wdat = 8'h00;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [7:0]  rdat;
   logic        true_ide;
   logic        ready;
   logic [4:0]  mode;
   logic        tf_wr;
   logic [2:0]  tf_addr;
   logic [7:0]  tf_data;
   int          n_fail = 0;
   int          num_checks = 0;
   int          n_tf = 0;
   logic [10:0] cis_a [4] = '{11'h000, 11'h002, 11'h008, 11'h001};
   logic [7:0]  cis_e [4] = '{8'h01, 8'h02, 8'hff, 8'h00};
   logic [7:0]  opt_v [4] = '{8'h00, 8'hc1, 8'h02, 8'h03};
   logic [10:0] tf_b  [4] = '{11'h000, 11'h000, 11'h1f0, 11'h170};
   logic [4:0]  mode_v [4] = '{CHSC_MODE_MEM, CHSC_MODE_CONT, CHSC_MODE_PRI, CHSC_MODE_SEC};

   chsc_if i_chsc_if ();
   chsc_host i_chsc_host (.CLK_SYS_I(clk), .NRST_I(nrst), .IDE_SEL_I(ide_sel), .ADDR_I(adr),
      .WDATA_I(wdat), .WR_I(wr), .RD_I(rd), .RDATA_O(rdat), .SOCK(i_chsc_if.host));
   chsc_card i_chsc_card (.CLK_SYS_I(clk), .NRST_I(nrst), .CARD(i_chsc_if.card),
      .TRUE_IDE_O(true_ide), .READY_O(ready), .MODE_O(mode), .TF_WR_O(tf_wr),
      .TF_ADDR_O(tf_addr), .TF_DATA_O(tf_data));
   chsc_props i_chsc_props (.CLK_SYS_I(clk), .NRST_I(nrst), .addr(i_chsc_if.addr),
      .host_d(i_chsc_if.host_d), .host_d_oe_n(i_chsc_if.host_d_oe_n),
      .card_d_oe_n(i_chsc_if.card_d_oe_n), .card_en_n(i_chsc_if.card_en_n),
      .mem_rd_n(i_chsc_if.mem_rd_n), .mem_wr_n(i_chsc_if.mem_wr_n),
      .io_rd_n(i_chsc_if.io_rd_n), .io_wr_n(i_chsc_if.io_wr_n),
      .attr_sel_n(i_chsc_if.attr_sel_n));

   always #50 clk = ~clk;

   // Counts command-file write pulses so each access can be judged by its delta
   always @(posedge clk) begin
      if (tf_wr === 1'b1) n_tf <= n_tf + 1;
   end

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : finish_test

   task automatic timeout(input string what);
      n_fail++;
      $display("BAD %s expected done seen hang", what);
      finish_test();
   endtask : timeout

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      adr  <= a;
      wdat <= d;
      wr   <= 1'b1;
      @(posedge clk);
      wr   <= 1'b0;
   endtask : reg_wr

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      adr <= a;
      rd  <= 1'b1;
      @(posedge clk);
      rd  <= 1'b0;
      #1 d = rdat;
   endtask : reg_rd

   // One socket access: load address and data, start it, then poll busy
   task automatic sock(input logic [1:0] sp, input logic rw, input logic [10:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [7:0] st;
      int         n;
      reg_wr(`CHSC_REG_ADDR_LO, a[7:0]);
      reg_wr(`CHSC_REG_ADDR_HI, {5'h0, a[10:8]});
      reg_wr(`CHSC_REG_WDATA, d);
      reg_wr(`CHSC_REG_CMD, {5'h0, sp, rw});
      n = 0;
      st = 8'h01;
      while (st[0] !== 1'b0) begin
         reg_rd(`CHSC_REG_STATUS, st);
         n++;
         if (n > 40) timeout("busy");
      end
      q = 8'h00;
      if (rw) reg_rd(`CHSC_REG_RDATA, q);
   endtask : sock

   // Strap level must be settled while reset is held
   task automatic do_reset(input logic ide);
      int n;
      @(posedge clk);
      nrst    <= 1'b0;
      ide_sel <= ide;
      repeat (4) @(posedge clk);
      nrst <= 1'b1;
      n = 0;
      while (ready !== 1'b1) begin
         @(posedge clk);
         n++;
         if (n > 20) timeout("ready");
      end
   endtask : do_reset

   initial begin
      logic [7:0] q;
      logic [1:0] sp;
      int         t;
      int         j;
      do_reset(1'b0);
      chk("true_ide", 8'h00, {7'h0, true_ide});
      chk("mode", {3'h0, CHSC_MODE_MEM}, {3'h0, mode});
      reg_rd(4'hf, q);
      chk("unmapped", 8'h00, q);
      for (int k = 1; k < 4; k++) begin
         sock(`CHSC_SPC_ATTR, 1'b0, `CHSC_CFG_OPTION + 11'(2 * k), 8'(8'h11 * k), q);
      end
      for (int k = 1; k < 4; k++) begin
         sock(`CHSC_SPC_ATTR, 1'b1, `CHSC_CFG_OPTION + 11'(2 * k), 8'h00, q);
         chk("cfg_reg", 8'(8'h11 * k), q);
         sock(`CHSC_SPC_ATTR, 1'b1, `CHSC_CFG_OPTION + 11'(2 * k + 1), 8'h00, q);
         chk("odd_cfg", 8'h00, q);
      end
      chk("mode", {3'h0, CHSC_MODE_MEM}, {3'h0, mode});
      for (int k = 0; k < 4; k++) begin
         sock(`CHSC_SPC_ATTR, 1'b1, cis_a[k], 8'h00, q);
         chk("cis", cis_e[k], q);
      end
      // Walk 1,2,3 and back to 0 so every step is a real mode change
      for (int k = 1; k < 5; k++) begin
         j = k % 4;
         sock(`CHSC_SPC_ATTR, 1'b0, `CHSC_CFG_OPTION, opt_v[j], q);
         sock(`CHSC_SPC_ATTR, 1'b1, `CHSC_CFG_OPTION, 8'h00, q);
         chk("option", opt_v[j], q);
         chk("mode", {3'h0, mode_v[j]}, {3'h0, mode});
         t = n_tf;
         sp = (j == 0) ? `CHSC_SPC_COMMON : `CHSC_SPC_IO;
         sock(sp, 1'b0, tf_b[j] + 11'(j + 4), 8'(8'h40 + j), q);
         chk("tf_hits", 8'(t + 1), 8'(n_tf));
         chk("tf_addr", 8'(j + 4), {5'h0, tf_addr});
         chk("tf_data", 8'(8'h40 + j), tf_data);
         sock(sp ^ 2'h3, 1'b0, tf_b[j] + 11'(j + 4), 8'h00, q);
         chk("tf_other", 8'(t + 1), 8'(n_tf));
      end
      // Reserved index values fall back to the memory map
      sock(`CHSC_SPC_ATTR, 1'b0, `CHSC_CFG_OPTION, 8'h05, q);
      chk("mode_rsv", {3'h0, CHSC_MODE_MEM}, {3'h0, mode});
      do_reset(1'b1);
      chk("true_ide", 8'h01, {7'h0, true_ide});
      chk("mode", {3'h0, CHSC_MODE_IDE}, {3'h0, mode});
      reg_rd(`CHSC_REG_STATUS, q);
      chk("status", 8'h02, q);
      t = n_tf;
      sock(`CHSC_SPC_ATTR, 1'b0, `CHSC_CFG_OPTION, 8'h01, q);
      chk("tf_hits", 8'(t + 1), 8'(n_tf));
      chk("tf_addr", 8'h00, {5'h0, tf_addr});
      reg_rd(`CHSC_REG_CMD, q);
      chk("cmd_space", 8'h04, q);
      chk("mode", {3'h0, CHSC_MODE_IDE}, {3'h0, mode});
      sock(`CHSC_SPC_IO, 1'b0, 11'h1f5, 8'h77, q);
      chk("tf_addr", 8'h05, {5'h0, tf_addr});
      chk("tf_data", 8'h77, tf_data);
      sock(`CHSC_SPC_IO, 1'b1, 11'h1f5, 8'h00, q);
      chk("tf_rd", 8'h77, q);
      reg_rd(`CHSC_REG_ADDR_LO, q);
      chk("addr_lo", 8'hf5, q);
      reg_rd(`CHSC_REG_ADDR_HI, q);
      chk("addr_hi", 8'h01, q);
      finish_test();
   end
endmodule : tb_card_host_space_config
